// >>> common/can_tx_defines.svh
// Offsets, field positions, codes and reset values of the transmit path
`ifndef CAN_TX_DEFINES_SVH
`define CAN_TX_DEFINES_SVH

`define SLOT_REGION_BASE 12'h080
`define SLOT_REGION_LAST 12'h17F
`define SLOT_BYTES 16
`define FLAGS_OFFSET 12'h030
`define TIMER_OFFSET 12'h008

// Control halfword fields
`define TS_MSB 15
`define TS_LSB 8
`define CODE_MSB 7
`define CODE_LSB 4
`define LEN_MSB 3
`define LEN_LSB 0
// Upper identifier halfword fields
`define SRR_BIT 4
`define IDE_BIT 3
// Lower identifier halfword: remote request sits in bit 0
`define RTR_BIT 0

`define CODE_TX_IDLE 4'h8
`define CODE_TX_ONCE 4'hC
`define CODE_TX_ONCE_RSP 4'hE
`define CODE_TX_RSP 4'hA
`define CODE_RX_EMPTY 4'h4
`define MAX_DATA_BYTES 4'h8

`define WORD_RESET 32'h0000_0000
`define TIMER_RESET 16'h0000
`endif

// >>> common/can_tx_pkg.sv
// Types shared by the transmit path
package can_tx_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_MOVE, ST_SEND} tx_state_t;

  typedef struct packed {
    logic [28:0] id;
    logic ide;
    logic srr;
    logic rtr;
    logic [3:0] dlc;
    logic [3:0] dataLen;
    logic [63:0] data;
  } shadow_frame_t;
endpackage

// >>> src/tx_pick.sv
// Lowest-identifier selection among ready frame slots
`timescale 1ns/1ps
`default_nettype none
module tx_pick #(
  parameter int SLOTS = 16,
  parameter int IW = $clog2(SLOTS)
) (
  input wire logic [SLOTS-1:0] ready,
  input wire logic [SLOTS*29-1:0] ids,
  output logic found,
  output logic [IW-1:0] winner
);
  logic [28:0] best;

  // Strict compare keeps the lower index on equal identifiers
  always_comb
  begin
    found = 1'b0;
    winner = '0;
    best = '1;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (ready[i] && (!found || ids[i*29 +: 29] < best))
      begin
        found = 1'b1;
        winner = IW'(i);
        best = ids[i*29 +: 29];
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/can_tx_path.sv
// Frame slot memory and transmit flow of the CAN controller
// What this block does
// - Extended: upper word holds identifier bits 28..15
// - Substitute remote bit sent as software wrote it
// - Extension bit chooses extended or standard format
// - Extended: lower word holds identifier bits 14..0
// - Extended: remote bit is lower word bit 0
// - Standard: remote sent one, sampled zero: arbitration lost
// - Standard: remote sent zero, sampled one: bit error
// - Standard: lower word gets 16-bit stamp
// - Slot region at 0x80, sixteen 16-byte slots
// - Sixteen slots, each up to eight bytes
// - Each slot owns one completion flag
// - Bus idle with ready slot starts arbitration
// - Winner copied into serial shadow buffer
// - At most eight data bytes sent
// - Success writes stamp, code, sets flag
// - Code 1100 data frame becomes 1000
// - Extended: stamp field gets timer high byte
// - Remote frame goes without data field
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "can_tx_defines.svh"
module can_tx_path
  import can_tx_pkg::*;
#(
  parameter int SLOTS = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic busIdle,
  input wire logic idStart,
  input wire logic txDone,
  input wire logic txFail,
  input wire logic rtrCheck,
  input wire logic rtrSampled,
  output logic frameValid,
  output shadow_frame_t frameOut,
  output logic arbLost,
  output logic bitErr,
  output logic [SLOTS-1:0] bufferEventFlags
);
  localparam int IW = $clog2(SLOTS);

  // ****************************************
  // Register bus
  // ****************************************
  logic [31:0] mem [SLOTS*4];
  logic [11:0] rel;
  logic inRegion;
  logic [IW+1:0] wordIdx;
  logic [31:0] lanes;
  logic setup;
  logic access;
  logic wrSlot;
  logic wrCtrl;
  logic [15:0] timerReg;
  logic [15:0] stampReg;

  assign rel = paddr - `SLOT_REGION_BASE;
  assign inRegion = paddr >= `SLOT_REGION_BASE && paddr <= `SLOT_REGION_LAST;
  assign wordIdx = rel[IW+3:2];
  assign lanes = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign wrSlot = access && pwrite && inRegion;
  assign wrCtrl = wrSlot && rel[3:2] == 2'b00 && |pstrb[3:2];

  // Read data and error are settled in the setup cycle, so no wait states
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= `WORD_RESET;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= 1'b0;
      prdata <= `WORD_RESET;
      if (inRegion)
        prdata <= mem[wordIdx];
      else if (paddr == `FLAGS_OFFSET)
        prdata <= 32'(bufferEventFlags);
      else if (paddr == `TIMER_OFFSET)
        prdata <= {16'h0000, timerReg};
      else
        pslverr <= 1'b1;
    end
  end

  // ****************************************
  // Timer and identifier-start capture
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timerReg <= `TIMER_RESET;
      stampReg <= `TIMER_RESET;
    end
    else
    begin
      timerReg <= timerReg + 16'h0001;
      if (idStart)
        stampReg <= timerReg;
    end
  end

  // ****************************************
  // Slot view and arbitration
  // ****************************************
  logic [SLOTS-1:0] ready;
  logic [SLOTS*29-1:0] ids;
  logic found;
  logic [IW-1:0] pickIdx;
  logic [IW-1:0] winReg;
  tx_state_t state;
  logic touched;
  logic hitWin;

  // A control write to the slot being picked or moved out deactivates it at once
  assign hitWin = wrCtrl && wordIdx[IW+1:2] == (state == ST_ARB ? pickIdx : winReg);

  always_comb
  begin
    for (int i = 0; i < SLOTS; i++)
    begin
      logic [31:0] w0;
      logic [31:0] w1;
      w0 = mem[i*4];
      w1 = mem[i*4+1];
      ready[i] = w0[16+`CODE_MSB:16+`CODE_LSB] == `CODE_TX_ONCE ||
                 w0[16+`CODE_MSB:16+`CODE_LSB] == `CODE_TX_ONCE_RSP;
      if (w0[`IDE_BIT])
        ids[i*29 +: 29] = {w0[15:5], w0[2:0], w1[31:17]};
      else
        ids[i*29 +: 29] = {w0[15:5], 18'h00000};
    end
  end

  tx_pick #(.SLOTS(SLOTS), .IW(IW)) pick (
    .ready(ready),
    .ids(ids),
    .found(found),
    .winner(pickIdx)
  );

  logic [31:0] winW0;
  logic [31:0] winW1;
  logic [3:0] winLen;
  logic [3:0] winCode;
  logic [3:0] nextCode;
  logic success;

  assign winW0 = mem[{winReg, 2'b00}];
  assign winW1 = mem[{winReg, 2'b01}];
  assign winLen = winW0[16+`LEN_MSB:16+`LEN_LSB];
  assign winCode = winW0[16+`CODE_MSB:16+`CODE_LSB];
  assign success = state == ST_SEND && txDone && !touched && !hitWin;

  always_comb
  begin
    if (winCode == `CODE_TX_ONCE_RSP)
      nextCode = `CODE_TX_RSP;
    else if (frameOut.rtr)
      nextCode = `CODE_RX_EMPTY;
    else
      nextCode = `CODE_TX_IDLE;
  end

  // ****************************************
  // Transmit sequencer
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      winReg <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (busIdle && |ready)
            state <= ST_ARB;
        ST_ARB:
        begin
          winReg <= pickIdx;
          state <= found ? ST_MOVE : ST_IDLE;
        end
        ST_MOVE:
          state <= (touched || hitWin) ? ST_IDLE : ST_SEND;
        ST_SEND:
          if (txDone || txFail)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // A control write to the chosen slot drops it from this round
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      touched <= 1'b0;
    else if (state == ST_IDLE)
      touched <= 1'b0;
    else if (hitWin)
      touched <= 1'b1;
  end

  // ****************************************
  // Serial shadow buffer
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      frameOut <= '0;
    else if (state == ST_MOVE && !touched && !hitWin)
    begin
      frameOut.ide <= winW0[`IDE_BIT];
      frameOut.srr <= winW0[`SRR_BIT];
      frameOut.dlc <= winLen;
      frameOut.data <= {winW1[15:0], mem[{winReg, 2'b10}], mem[{winReg, 2'b11}][31:16]};
      if (winW0[`IDE_BIT])
      begin
        frameOut.id <= {winW0[15:5], winW0[2:0], winW1[31:17]};
        frameOut.rtr <= winW1[16+`RTR_BIT];
      end
      else
      begin
        frameOut.id <= {winW0[15:5], 18'h00000};
        frameOut.rtr <= winW0[`SRR_BIT];
      end
      if ((winW0[`IDE_BIT] && winW1[16+`RTR_BIT]) || (!winW0[`IDE_BIT] && winW0[`SRR_BIT]))
        frameOut.dataLen <= 4'h0;
      else
        frameOut.dataLen <= winLen > `MAX_DATA_BYTES ? `MAX_DATA_BYTES : winLen;
    end
  end

  assign frameValid = state == ST_SEND;

  // Standard frames only: the remote bit is compared bit by bit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arbLost <= 1'b0;
      bitErr <= 1'b0;
    end
    else
    begin
      arbLost <= frameValid && rtrCheck && !frameOut.ide && frameOut.rtr && !rtrSampled;
      bitErr <= frameValid && rtrCheck && !frameOut.ide && !frameOut.rtr && rtrSampled;
    end
  end

  // ****************************************
  // Slot memory and completion update
  // ****************************************
  // The software write wins a word both sides touch in one cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < SLOTS*4; i++)
        mem[i] <= `WORD_RESET;
    end
    else
    begin
      if (success)
      begin
        mem[{winReg, 2'b00}][16+`CODE_MSB:16+`CODE_LSB] <= nextCode;
        if (frameOut.ide)
          mem[{winReg, 2'b00}][16+`TS_MSB:16+`TS_LSB] <= stampReg[15:8];
        else if (!(wrSlot && wordIdx == {winReg, 2'b01}))
          mem[{winReg, 2'b01}][31:16] <= stampReg;
      end
      if (wrSlot)
        mem[wordIdx] <= (mem[wordIdx] & ~lanes) | (pwdata & lanes);
    end
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      bufferEventFlags <= '0;
    else
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        if (success && winReg == IW'(i))
          bufferEventFlags[i] <= 1'b1;
        else if (access && pwrite && paddr == `FLAGS_OFFSET && pwdata[i])
          bufferEventFlags[i] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence sq_won;
    state == ST_ARB && found;
  endsequence
  sequence sq_moved;
    state == ST_MOVE && !touched && !hitWin;
  endsequence

  chk_ext_id_split: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sq_moved and winW0[`IDE_BIT] |=> frameOut.id[28:15] == $past({winW0[15:5], winW0[2:0]}))
    else $error("extended upper identifier not copied");
  chk_ext_lower_identifier_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sq_moved and winW0[`IDE_BIT] |=> frameOut.id[14:0] == $past(winW1[31:17]))
    else $error("extended lower identifier not copied");
  chk_ext_rtr_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sq_moved and winW0[`IDE_BIT] |=> frameOut.rtr == $past(winW1[16]))
    else $error("extended remote bit wrong");
  chk_arb_lost: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frameValid && rtrCheck && !frameOut.ide && frameOut.rtr && !rtrSampled |=> arbLost)
    else $error("arbitration loss not flagged");
  chk_bit_error: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frameValid && rtrCheck && !frameOut.ide && (frameOut.rtr == rtrSampled) |=> !bitErr && !arbLost)
    else $error("matching remote bit flagged");
  chk_std_stamp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    success && !frameOut.ide && !wrSlot |=> winW1[31:16] == $past(stampReg))
    else $error("standard stamp not stored");
  chk_unmapped_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    setup && !inRegion && paddr != `FLAGS_OFFSET && paddr != `TIMER_OFFSET |=> pslverr)
    else $error("unmapped access not refused");
  chk_flag_on_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    success |=> bufferEventFlags[$past(winReg)])
    else $error("completion flag not set");
  chk_arb_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == ST_IDLE && busIdle && |ready |=> state == ST_ARB)
    else $error("arbitration did not start");
  chk_move_send: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sq_won ##1 sq_moved |=> frameValid)
    else $error("winner not moved out");
  chk_data_clamp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frameValid |-> frameOut.dataLen <= `MAX_DATA_BYTES && (!frameOut.rtr || frameOut.dataLen == 0))
    else $error("data length over eight or remote with data");
  chk_code_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    success && winCode == `CODE_TX_ONCE && !frameOut.rtr && !wrSlot |=> winCode == `CODE_TX_IDLE)
    else $error("code not returned to idle");
  chk_lowest_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sq_won |=> !ready[winReg] || ids[winReg*29 +: 29] <= $past(ids[pickIdx*29 +: 29]) || touched)
    else $error("winner identifier changed");
endmodule
`default_nettype wire

// >>> bench/can_link_model.sv
// Bus-side model that answers the shadow frame
`timescale 1ns/1ps
`default_nettype none
module can_link_model
  import can_tx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic idleReq,
  input wire logic flipRtr,
  input wire logic frameValid,
  input wire shadow_frame_t frameOut,
  output logic busIdle,
  output logic idStart,
  output logic txDone,
  output logic txFail,
  output logic rtrCheck,
  output logic rtrSampled
);
  logic [3:0] stepReg;
  // Bus counts as free only while nothing is on the wire
  assign busIdle = idleReq & !frameValid;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      stepReg <= 4'h0;
    else
      stepReg <= frameValid ? stepReg + 4'h1 : 4'h0;
  end
  assign idStart = stepReg == 4'h1;
  assign rtrCheck = stepReg == 4'h3;
  // Outside the check slot the line shows the inverse, never a stale copy
  assign rtrSampled = rtrCheck ? frameOut.rtr ^ flipRtr : !frameOut.rtr;
  assign txDone = stepReg == 4'h5 && !flipRtr;
  assign txFail = stepReg == 4'h5 && flipRtr;
endmodule
`default_nettype wire

// >>> bench/test_can_tx_path.sv
// Self-checking bench of the CAN transmit path
`timescale 1ns/1ps
`default_nettype none
`include "can_tx_defines.svh"
module test_can_tx_path
  import can_tx_pkg::*;
;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, rdErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic busIdle, idStart, txDone, txFail, rtrCheck, rtrSampled;
  logic frameValid, arbLost, bitErr, idleReq, flipRtr;
  logic [15:0] bufferEventFlags;
  shadow_frame_t frameOut, got;
  int err_total, compares, lostCnt, bitCnt;

  can_tx_path i_can_tx_path (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busIdle(busIdle),
    .idStart(idStart), .txDone(txDone), .txFail(txFail), .rtrCheck(rtrCheck),
    .rtrSampled(rtrSampled), .frameValid(frameValid), .frameOut(frameOut),
    .arbLost(arbLost), .bitErr(bitErr), .bufferEventFlags(bufferEventFlags));
  can_link_model i_can_link_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .idleReq(idleReq), .flipRtr(flipRtr), .frameValid(frameValid),
    .frameOut(frameOut), .busIdle(busIdle), .idStart(idStart), .txDone(txDone),
    .txFail(txFail), .rtrCheck(rtrCheck), .rtrSampled(rtrSampled));

  initial
  begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Error pulses last one cycle, so they are counted here
  always @(posedge ref_clk)
  begin
    if (arbLost === 1'h1)
      lostCnt <= lostCnt + 1;
    if (bitErr === 1'h1)
      bitCnt <= bitCnt + 1;
  end

  // ********************
  // Shared tasks
  // ********************
  task end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task hang;
    err_total++;
    end_of_test;
  endtask
  task chk(input logic [31:0] exp, input logic [31:0] act);
    compares++;
    if (act !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, exp, act);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (n >= 20)
      hang;
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function logic [11:0] sb(input int s);
    return `SLOT_REGION_BASE + 12'(s * `SLOT_BYTES);
  endfunction
  task load(input int s, input logic [28:0] id, input logic ext, input logic rtr,
    input logic [3:0] len, input logic [63:0] dat);
    logic [15:0] up, lo;
    up = ext ? {id[28:18], 2'h3, id[17:15]} : {id[28:18], rtr, 4'h0};
    lo = ext ? {id[14:0], rtr} : 16'h0000;
    apb(sb(s), 1'h1, {16'h0080, up});
    apb(sb(s) + 12'h004, 1'h1, {lo, dat[63:48]});
    apb(sb(s) + 12'h008, 1'h1, dat[47:16]);
    apb(sb(s) + 12'h00C, 1'h1, {dat[15:0], 16'h0000});
    apb(sb(s), 1'h1, {8'h00, 4'hC, len, up});
  endtask
  task waitFv(input logic lvl);
    int n;
    n = 0;
    while (frameValid !== lvl && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 40)
      hang;
  endtask
  task send(input logic flip);
    @(posedge ref_clk);
    flipRtr <= flip;
    idleReq <= 1'h1;
    waitFv(1'h1);
    got = frameOut;
    @(posedge ref_clk);
    idleReq <= 1'h0;
    waitFv(1'h0);
  endtask
  task flagChk(input logic [15:0] exp);
    chk(exp, bufferEventFlags);
    apb(`FLAGS_OFFSET, 1'h0, 32'h0);
    chk(exp, rd);
    apb(`FLAGS_OFFSET, 1'h1, 32'h0000FFFF);
  endtask

  // ********************
  // Scenarios
  // ********************
  task scnMap;
    apb(12'h17C, 1'h0, 32'h0);
    chk(0, rdErr);
    apb(12'h180, 1'h0, 32'h0);
    chk(1, rdErr);
    chk(0, rd);
    apb(12'h098, 1'h1, 32'hAABBCCDD);
    pstrb <= 4'h3;
    apb(12'h098, 1'h1, 32'h11223344);
    pstrb <= 4'hF;
    apb(12'h098, 1'h0, 32'h0);
    chk(32'hAABB3344, rd);
  endtask
  task scnExtended;
    logic [31:0] t1;
    // Let the timer high byte leave zero so a stuck stamp cannot pass
    repeat (300) @(posedge ref_clk);
    apb(`TIMER_OFFSET, 1'h0, 32'h0);
    t1 = rd;
    load(3, 29'h1A5C3E96, 1'h1, 1'h0, 4'hA, 64'h1122334455667788);
    send(1'h0);
    chk(29'h1A5C3E96, got.id);
    chk(3'h6, {got.ide, got.srr, got.rtr});
    chk(4'hA, got.dlc);
    chk(4'h8, got.dataLen);
    chk(32'h11223344, got.data[63:32]);
    chk(32'h55667788, got.data[31:0]);
    flagChk(16'h0008);
    apb(sb(3), 1'h0, 32'h0);
    chk(4'h8, rd[23:20]);
    t1[31:24] = rd[31:24];
    apb(`TIMER_OFFSET, 1'h0, 32'h0);
    chk(1, t1[31:24] >= t1[15:8] && t1[31:24] <= rd[15:8]);
  endtask
  task scnArb;
    load(2, 29'h200, 1'h1, 1'h0, 4'h0, 64'h0);
    load(15, 29'h100, 1'h1, 1'h0, 4'h0, 64'h0);
    load(6, 29'h100, 1'h1, 1'h0, 4'h0, 64'h0);
    send(1'h0);
    flagChk(16'h0040);
    send(1'h0);
    flagChk(16'h8000);
    send(1'h0);
    flagChk(16'h0004);
    load(5, 29'h300, 1'h1, 1'h0, 4'h1, 64'h0);
    apb(sb(5), 1'h1, 32'h0080_0018);
    apb(sb(5), 1'h1, 32'h00E1_0018);
    send(1'h0);
    flagChk(16'h0020);
    apb(sb(5), 1'h0, 32'h0);
    chk(4'hA, rd[23:20]);
  endtask
  task scnRemote;
    load(0, 29'h0F0F0F0F, 1'h1, 1'h1, 4'h4, 64'h0);
    send(1'h0);
    chk(1, got.rtr);
    chk(0, got.dataLen);
    flagChk(16'h0001);
    apb(sb(0), 1'h0, 32'h0);
    chk(4'h4, rd[23:20]);
  endtask
  task scnStandard;
    int l0, b0;
    logic [31:0] t1;
    l0 = lostCnt;
    b0 = bitCnt;
    load(9, {11'h123, 18'h0}, 1'h0, 1'h1, 4'h2, 64'h0);
    send(1'h1);
    chk(l0 + 1, lostCnt);
    load(9, {11'h123, 18'h0}, 1'h0, 1'h0, 4'h2, 64'h0);
    send(1'h1);
    chk(b0 + 1, bitCnt);
    flagChk(16'h0000);
    apb(`TIMER_OFFSET, 1'h0, 32'h0);
    t1 = rd;
    load(9, {11'h123, 18'h0}, 1'h0, 1'h0, 4'h2, 64'h0);
    send(1'h0);
    chk(l0 + b0 + 2, lostCnt + bitCnt);
    chk(11'h123, got.id[28:18]);
    flagChk(16'h0200);
    apb(sb(9) + 12'h004, 1'h0, 32'h0);
    t1[31:16] = rd[31:16];
    apb(`TIMER_OFFSET, 1'h0, 32'h0);
    chk(1, t1[31:16] > t1[15:0] && t1[31:16] < rd[15:0]);
  endtask

  initial
  begin
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    idleReq = 1'h0;
    flipRtr = 1'h0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'h1;
    scnMap;
    scnExtended;
    scnArb;
    scnRemote;
    scnStandard;
    end_of_test;
  end
endmodule
`default_nettype wire
